// >>> ccw_regs.sv
/*
  Charger control and watchdog register group behind an I2C target port.
  Holds the serial target, the general and charge control registers,
  the live status view and the effective switching-frequency logic.
  Assumes SCL and SDA arrive asynchronously on pins with external
  pull-ups, and that ADC request, done and mode come from core logic.
*/
//
// Functional notes
// - soft reset bit restores defaults, reads zero
// - three-bit code selects switching frequency
// - master or slave caps frequency at 500 kHz
// - frequency code survives soft reset and watchdog
// - expiry sets flag and interrupt; read clears
// - disable bit stops the watchdog
// - two-bit code selects watchdog period
// - every completed transaction addressed to this target restarts the watchdog
// - role field reports strap: standalone, slave, master
// - shift field nudges or spreads the frequency
// - connector temperature protection disable bit
// - battery temperature protection disable bit
// - die temperature protection disable, soft-reset cleared
// - live alarm bits follow present conditions
// - status bits seven to one carry alarms, presence
// - conversion-done bit: one-shot request clears, completion sets; continuous low
//
`timescale 1ns/1ps
module ccw_regs
  import ccw_pkg::*;
#(
  parameter logic [6:0]          DEV_ADDR = 7'h6A,  // arbitrary target address
  parameter logic [WD_CNT_W-1:0] WD_CYC_0_P = WD_CYC_0,
  parameter logic [WD_CNT_W-1:0] WD_CYC_1_P = WD_CYC_1,
  parameter logic [WD_CNT_W-1:0] WD_CYC_2_P = WD_CYC_2,
  parameter logic [WD_CNT_W-1:0] WD_CYC_3_P = WD_CYC_3
) (
  input  wire logic       CLOCK_I,
  input  wire logic       RESETN_I,
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OEN_O,
  input  wire logic [1:0] ROLE_I,
  input  wire logic [6:0] ALARM_LIVE_I,
  input  wire logic       ADC_ONESHOT_REQ_I,
  input  wire logic       ADC_CONV_DONE_I,
  input  wire logic       ADC_CONTINUOUS_I,
  output logic            CHARGE_ENABLE_O,
  output logic [2:0]      FSW_CODE_O,
  output logic [1:0]      FREQ_SHIFT_O,
  output logic            CONN_TEMP_PROT_DIS_O,
  output logic            BATT_TEMP_PROT_DIS_O,
  output logic            DIE_TEMP_PROT_DIS_O,
  output logic            WATCHDOG_INT_O
);

  // ******************************************************************
  // types
  // ******************************************************************
  typedef enum logic [6:0] {
    ST_IDLE     = 7'b0000001,
    ST_ADDR     = 7'b0000010,
    ST_ADDR_ACK = 7'b0000100,
    ST_WR       = 7'b0001000,
    ST_WR_ACK   = 7'b0010000,
    ST_RD       = 7'b0100000,
    ST_RD_ACK   = 7'b1000000
  } ccw_i2c_st_t;

  typedef struct packed {
    ccw_i2c_st_t st;
    logic [3:0]  bitcnt;
    logic [7:0]  sh;
    logic [7:0]  ptr;
    logic        ptr_set;
    logic        rw;
    logic        addr_hit;
    logic        host_ack;
    logic        scl_q;
    logic        sda_q;
    logic        sda_oen;
    logic [2:0]  fsw_sel;
    logic [2:0]  fsw_eff;
    logic        watchdog_expired_flag;
    logic        watchdog_disable;
    logic [1:0]  wd_period;
    logic        charge_enable;
    logic [1:0]  freq_shift_select;
    logic        connector_temp_prot_disable;
    logic        battery_temp_prot_disable;
    logic        die_temp_prot_disable;
    logic        adc_done;
    logic        wd_int;
    logic        kick;
  } ccw_state_t;

  localparam ccw_state_t STATE_RST = '{
    st:                          ST_IDLE,
    bitcnt:                      4'h0,
    sh:                          8'h00,
    ptr:                         8'h00,
    ptr_set:                     1'b0,
    rw:                          1'b0,
    addr_hit:                    1'b0,
    host_ack:                    1'b0,
    scl_q:                       1'b0,
    sda_q:                       1'b0,
    sda_oen:                     1'b1,
    fsw_sel:                     GEN_CTRL_RST[GC_FSW_LSB +: 3],
    fsw_eff:                     GEN_CTRL_RST[GC_FSW_LSB +: 3],
    watchdog_expired_flag:       GEN_CTRL_RST[GC_WD_FLAG_BIT],
    watchdog_disable:            GEN_CTRL_RST[GC_WD_DIS_BIT],
    wd_period:                   GEN_CTRL_RST[GC_WD_PER_LSB +: 2],
    charge_enable:               CHG_CTRL_RST[CC_CHARGE_ENABLE_BIT],
    freq_shift_select:           CHG_CTRL_RST[CC_FSHIFT_LSB +: 2],
    connector_temp_prot_disable: CHG_CTRL_RST[CC_TSBUS_BIT],
    battery_temp_prot_disable:   CHG_CTRL_RST[CC_TSBAT_BIT],
    die_temp_prot_disable:       CHG_CTRL_RST[CC_TDIE_BIT],
    adc_done:                    ADC_DONE_RST,
    wd_int:                      1'b0,
    kick:                        1'b0
  };

  // ******************************************************************
  // signals
  // ******************************************************************
  ccw_state_t  s_r;
  ccw_state_t  s_nxt;
  logic [10:0] sync_q;
  logic        scl;
  logic        sda;
  logic [6:0]  alarm_live;
  logic [1:0]  operating_role;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic        live_done;
  logic [7:0]  rd_val;
  logic        wr_en;
  logic        load_rd;

  ccw_wdog_if wdog ();

  // ******************************************************************
  // pin synchronisers and watchdog
  // ******************************************************************
  ccw_sync #(
    .WIDTH (11)
  ) u_sync (
    .clk_i  (CLOCK_I),
    .rstn_i (RESETN_I),
    .d_i    ({ROLE_I, ALARM_LIVE_I, SDA_I, SCL_I}),
    .q_o    (sync_q)
  );

  ccw_wdog #(
    .CYC_0 (WD_CYC_0_P),
    .CYC_1 (WD_CYC_1_P),
    .CYC_2 (WD_CYC_2_P),
    .CYC_3 (WD_CYC_3_P)
  ) u_wdog (
    .clk_i  (CLOCK_I),
    .rstn_i (RESETN_I),
    .wd     (wdog.timer)
  );

  // split the synchronised vector
  assign scl            = sync_q[0];
  assign sda            = sync_q[1];
  assign alarm_live     = sync_q[8:2];
  assign operating_role = sync_q[10:9];

  // watchdog control straight from registers
  assign wdog.kick       = s_r.kick;
  assign wdog.enable     = ~s_r.watchdog_disable;
  assign wdog.period_sel = s_r.wd_period;

  // bus conditions, judged on settled copies only
  assign scl_rise  = scl & ~s_r.scl_q;
  assign scl_fall  = ~scl & s_r.scl_q;
  assign bus_start = scl & s_r.scl_q & s_r.sda_q & ~sda;
  assign bus_stop  = scl & s_r.scl_q & ~s_r.sda_q & sda;

  // continuous mode forces the done bit low
  assign live_done = s_r.adc_done & ~ADC_CONTINUOUS_I;

  // ******************************************************************
  // read data mux
  // ******************************************************************
  always_comb begin
    rd_val = UNMAPPED_RD_VAL;
    unique case (s_r.ptr)
      OFF_GEN_CTRL: begin
        rd_val                         = 8'h00;  // soft reset bit reads zero
        rd_val[GC_FSW_LSB +: 3]        = s_r.fsw_sel;
        rd_val[GC_WD_FLAG_BIT]         = s_r.watchdog_expired_flag;
        rd_val[GC_WD_DIS_BIT]          = s_r.watchdog_disable;
        rd_val[GC_WD_PER_LSB +: 2]     = s_r.wd_period;
      end
      OFF_CHG_CTRL: begin
        rd_val[CC_CHARGE_ENABLE_BIT]          = s_r.charge_enable;
        rd_val[CC_ROLE_LSB +: 2]       = operating_role;
        rd_val[CC_FSHIFT_LSB +: 2]     = s_r.freq_shift_select;
        rd_val[CC_TSBUS_BIT]           = s_r.connector_temp_prot_disable;
        rd_val[CC_TSBAT_BIT]           = s_r.battery_temp_prot_disable;
        rd_val[CC_TDIE_BIT]            = s_r.die_temp_prot_disable;
      end
      OFF_LIVE_STAT: begin
        rd_val = {alarm_live, live_done};  // alarms unlatched, present state; done bit held until a request
      end
      default: rd_val = UNMAPPED_RD_VAL;
    endcase
  end

  // ******************************************************************
  // serial target, register updates, watchdog effects
  // ******************************************************************
  always_comb begin
    s_nxt       = s_r;
    s_nxt.scl_q = scl;
    s_nxt.sda_q = sda;
    s_nxt.kick  = 1'b0;
    s_nxt.wd_int = 1'b0;
    wr_en       = 1'b0;
    load_rd     = 1'b0;

    // start and stop override any bit in flight
    if (bus_start) begin
      s_nxt.st       = ST_ADDR;
      s_nxt.bitcnt   = 4'h0;
      s_nxt.sda_oen  = 1'b1;
      s_nxt.addr_hit = 1'b0;
      s_nxt.ptr_set  = 1'b0;
    end else if (bus_stop) begin
      s_nxt.kick     = s_r.addr_hit;  // completed transaction
      s_nxt.st       = ST_IDLE;
      s_nxt.sda_oen  = 1'b1;
      s_nxt.addr_hit = 1'b0;
    end else begin
      unique case (s_r.st)
        ST_IDLE: begin
          s_nxt.sda_oen = 1'b1;
        end
        ST_ADDR, ST_WR: begin
          if (scl_rise) begin
            s_nxt.sh     = {s_r.sh[6:0], sda};
            s_nxt.bitcnt = s_r.bitcnt + 4'h1;
          end else if (scl_fall && s_r.bitcnt == BITS_PER_BYTE) begin
            s_nxt.bitcnt = 4'h0;
            if (s_r.st == ST_ADDR) begin
              // silently drop frames aimed at other targets
              if (s_r.sh[7:1] == DEV_ADDR) begin
                s_nxt.addr_hit = 1'b1;
                s_nxt.rw       = s_r.sh[0];
                s_nxt.st       = ST_ADDR_ACK;
                s_nxt.sda_oen  = 1'b0;
              end else begin
                s_nxt.st = ST_IDLE;
              end
            end else begin
              s_nxt.st      = ST_WR_ACK;
              s_nxt.sda_oen = 1'b0;
              if (!s_r.ptr_set) begin
                s_nxt.ptr     = s_r.sh;
                s_nxt.ptr_set = 1'b1;
              end else begin
                wr_en     = 1'b1;
                s_nxt.ptr = s_r.ptr + 8'h01;
              end
            end
          end
        end
        ST_ADDR_ACK, ST_WR_ACK: begin
          if (scl_fall) begin
            if (s_r.st == ST_ADDR_ACK && s_r.rw) begin
              load_rd = 1'b1;
            end else begin
              s_nxt.sda_oen = 1'b1;
              s_nxt.st      = ST_WR;
            end
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (s_r.bitcnt == BITS_PER_BYTE) begin
              s_nxt.sda_oen = 1'b1;
              s_nxt.st      = ST_RD_ACK;
            end else begin
              s_nxt.sda_oen = s_r.sh[7];
              s_nxt.sh      = {s_r.sh[6:0], 1'b0};
              s_nxt.bitcnt  = s_r.bitcnt + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            s_nxt.host_ack = ~sda;
          end else if (scl_fall) begin
            if (s_r.host_ack) begin
              load_rd = 1'b1;
            end else begin
              s_nxt.st = ST_IDLE;  // host nack, wait for stop
            end
          end
        end
        default: begin
          s_nxt.st      = ST_IDLE;
          s_nxt.sda_oen = 1'b1;
        end
      endcase
    end

    // fetch a byte for the host, reads auto-increment the pointer
    if (load_rd) begin
      s_nxt.sh      = {rd_val[6:0], 1'b0};
      s_nxt.sda_oen = rd_val[7];
      s_nxt.ptr     = s_r.ptr + 8'h01;
      s_nxt.bitcnt  = 4'h1;
      s_nxt.st      = ST_RD;
      if (s_r.ptr == OFF_GEN_CTRL) begin
        s_nxt.watchdog_expired_flag = 1'b0;  // cleared by the read
      end
    end

    // register writes
    if (wr_en) begin
      unique case (s_r.ptr)
        OFF_GEN_CTRL: begin
          s_nxt.fsw_sel          = s_r.sh[GC_FSW_LSB +: 3];
          s_nxt.watchdog_disable = s_r.sh[GC_WD_DIS_BIT];
          s_nxt.wd_period        = s_r.sh[GC_WD_PER_LSB +: 2];
          if (s_r.sh[GC_SOFT_RST_BIT]) begin
            // everything but the frequency code goes back to default
            s_nxt.watchdog_expired_flag       = GEN_CTRL_RST[GC_WD_FLAG_BIT];
            s_nxt.watchdog_disable            = GEN_CTRL_RST[GC_WD_DIS_BIT];
            s_nxt.wd_period                   = GEN_CTRL_RST[GC_WD_PER_LSB +: 2];
            s_nxt.charge_enable               = CHG_CTRL_RST[CC_CHARGE_ENABLE_BIT];
            s_nxt.freq_shift_select           = CHG_CTRL_RST[CC_FSHIFT_LSB +: 2];
            s_nxt.connector_temp_prot_disable = CHG_CTRL_RST[CC_TSBUS_BIT];
            s_nxt.battery_temp_prot_disable   = CHG_CTRL_RST[CC_TSBAT_BIT];
            s_nxt.die_temp_prot_disable       = CHG_CTRL_RST[CC_TDIE_BIT];
            s_nxt.kick                        = 1'b1;
          end
        end
        OFF_CHG_CTRL: begin
          s_nxt.charge_enable               = s_r.sh[CC_CHARGE_ENABLE_BIT];
          s_nxt.freq_shift_select           = s_r.sh[CC_FSHIFT_LSB +: 2];
          s_nxt.connector_temp_prot_disable = s_r.sh[CC_TSBUS_BIT];
          s_nxt.battery_temp_prot_disable   = s_r.sh[CC_TSBAT_BIT];
          s_nxt.die_temp_prot_disable       = s_r.sh[CC_TDIE_BIT];
        end
        default: begin
          s_nxt.ptr = s_r.ptr + 8'h01;  // role, status and holes ignore writes
        end
      endcase
    end

    // conversion tracking; a new request beats a stale completion
    if (ADC_ONESHOT_REQ_I) begin
      s_nxt.adc_done = 1'b0;
    end else if (ADC_CONV_DONE_I) begin
      s_nxt.adc_done = 1'b1;
    end

    // expiry last, so it beats a same-cycle read clear or soft reset
    if (wdog.expired) begin
      s_nxt.watchdog_expired_flag = 1'b1;
      s_nxt.wd_int                = 1'b1;
      s_nxt.charge_enable         = 1'b0;
    end

    // paired devices must not exceed the 500 kHz code
    if (operating_role != ROLE_STANDALONE && s_nxt.fsw_sel > FSW_500K) begin
      s_nxt.fsw_eff = FSW_500K;
    end else begin
      s_nxt.fsw_eff = s_nxt.fsw_sel;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ******************************************************************
  // outputs, all from flops except the tied-low SDA_O
  // ******************************************************************
  assign SDA_O                = 1'b0;  // open drain, only ever pulls low
  assign SDA_OEN_O            = s_r.sda_oen;
  assign CHARGE_ENABLE_O      = s_r.charge_enable;
  assign FSW_CODE_O           = s_r.fsw_eff;
  assign FREQ_SHIFT_O         = s_r.freq_shift_select;
  assign CONN_TEMP_PROT_DIS_O = s_r.connector_temp_prot_disable;
  assign BATT_TEMP_PROT_DIS_O = s_r.battery_temp_prot_disable;
  assign DIE_TEMP_PROT_DIS_O  = s_r.die_temp_prot_disable;
  assign WATCHDOG_INT_O       = s_r.wd_int;
endmodule

// >>> ccw_pkg.sv
/*
  Constants shared by the charger control and watchdog register group:
  register offsets, field positions, reset values, frequency codes and
  watchdog periods. Assumes a 200 MHz core clock.
*/
package ccw_pkg;

  // ******************************************************************
  // register map (byte-wide registers, offsets on the serial bus)
  // ******************************************************************
  localparam logic [7:0] OFF_GEN_CTRL    = 8'h0B;
  localparam logic [7:0] OFF_CHG_CTRL    = 8'h0C;
  localparam logic [7:0] OFF_LIVE_STAT   = 8'h0D;
  localparam logic [7:0] GEN_CTRL_RST    = 8'h40;
  localparam logic [7:0] CHG_CTRL_RST    = 8'h00;
  localparam logic [7:0] UNMAPPED_RD_VAL = 8'h00;

  // ******************************************************************
  // field positions
  // ******************************************************************
  localparam int GC_SOFT_RST_BIT = 7;
  localparam int GC_FSW_LSB      = 4;
  localparam int GC_WD_FLAG_BIT  = 3;
  localparam int GC_WD_DIS_BIT   = 2;
  localparam int GC_WD_PER_LSB   = 0;
  localparam int CC_CHARGE_ENABLE_BIT   = 7;
  localparam int CC_ROLE_LSB     = 5;
  localparam int CC_FSHIFT_LSB   = 3;
  localparam int CC_TSBUS_BIT    = 2;
  localparam int CC_TSBAT_BIT    = 1;
  localparam int CC_TDIE_BIT     = 0;

  // ******************************************************************
  // frequency and role codes
  // ******************************************************************
  localparam logic [2:0] FSW_500K        = 3'h4;  // ceiling when paired
  localparam logic [1:0] ROLE_STANDALONE = 2'h0;
  localparam logic       ADC_DONE_RST    = 1'b1;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

  // ******************************************************************
  // watchdog periods and their cycle counts
  // ******************************************************************
  localparam longint CLK_FREQ_HZ = 200_000_000;
  localparam longint WD_T0_MS    = 500;
  localparam longint WD_T1_MS    = 1000;
  localparam longint WD_T2_MS    = 5000;
  localparam longint WD_T3_MS    = 30000;
  localparam int     WD_CNT_W    = 36;
  localparam logic [WD_CNT_W-1:0] WD_CYC_0 = WD_CNT_W'(WD_T0_MS * CLK_FREQ_HZ / 1000);
  localparam logic [WD_CNT_W-1:0] WD_CYC_1 = WD_CNT_W'(WD_T1_MS * CLK_FREQ_HZ / 1000);
  localparam logic [WD_CNT_W-1:0] WD_CYC_2 = WD_CNT_W'(WD_T2_MS * CLK_FREQ_HZ / 1000);
  localparam logic [WD_CNT_W-1:0] WD_CYC_3 = WD_CNT_W'(WD_T3_MS * CLK_FREQ_HZ / 1000);

endpackage

// >>> ccw_wdog_if.sv
/*
  Carrier between the register group and its watchdog timer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface ccw_wdog_if;
  logic       kick;        // restart pulse
  logic       enable;      // level, high while counting allowed
  logic [1:0] period_sel;  // period code
  logic       expired;     // one-cycle expiry pulse

  modport ctrl  (output kick, output enable, output period_sel, input expired);
  modport timer (input kick, input enable, input period_sel, output expired);
endinterface

// >>> ccw_sync.sv
/*
  Two-flop synchroniser for a vector of asynchronous inputs.
  Assumes each bit is an independent level; no bus coherency is given.
*/
`timescale 1ns/1ps
module ccw_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } ccw_sync_st_t;

  ccw_sync_st_t s_r;
  ccw_sync_st_t s_nxt;

  // first stage feeds only the second stage
  always_comb begin
    s_nxt.meta   = d_i;
    s_nxt.stable = s_r.meta;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q_o = s_r.stable;
endmodule

// >>> ccw_wdog.sv
/*
  Host-communication watchdog counter.
  Assumes the kick and enable come from same-clock register logic.
*/
`timescale 1ns/1ps
module ccw_wdog
  import ccw_pkg::*;
#(
  parameter logic [WD_CNT_W-1:0] CYC_0 = WD_CYC_0,
  parameter logic [WD_CNT_W-1:0] CYC_1 = WD_CYC_1,
  parameter logic [WD_CNT_W-1:0] CYC_2 = WD_CYC_2,
  parameter logic [WD_CNT_W-1:0] CYC_3 = WD_CYC_3
) (
  input  wire logic  clk_i,
  input  wire logic  rstn_i,
  ccw_wdog_if.timer  wd
);
  typedef struct packed {
    logic [WD_CNT_W-1:0] cnt;
    logic                expired;
  } ccw_wdog_st_t;

  ccw_wdog_st_t        s_r;
  ccw_wdog_st_t        s_nxt;
  logic [WD_CNT_W-1:0] limit;

  // period lookup
  always_comb begin
    unique case (wd.period_sel)
      2'h0: limit = CYC_0;
      2'h1: limit = CYC_1;
      2'h2: limit = CYC_2;
      2'h3: limit = CYC_3;
    endcase
  end

  // >= rather than == so a shortened period never lets the count wrap
  always_comb begin
    s_nxt         = s_r;
    s_nxt.expired = 1'b0;
    if (!wd.enable || wd.kick) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt >= limit - WD_CNT_W'(1)) begin
      s_nxt.cnt     = '0;
      s_nxt.expired = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + WD_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wd.expired = s_r.expired;
endmodule

// >>> ccw_regs_chk.sv
/* port checker for ccw_regs.
   assumes binding to the top; serial pins seen raw, before sync. */
`timescale 1ns/1ps
module ccw_regs_chk
  import ccw_pkg::*;
(
  input wire logic       CLOCK_I,
  input wire logic       RESETN_I,
  input wire logic       SCL_I,
  input wire logic [1:0] ROLE_I,
  input wire logic       SDA_OEN_O,
  input wire logic       CHARGE_ENABLE_O,
  input wire logic [2:0] FSW_CODE_O,
  input wire logic [1:0] FREQ_SHIFT_O,
  input wire logic       CONN_TEMP_PROT_DIS_O,
  input wire logic       BATT_TEMP_PROT_DIS_O,
  input wire logic       DIE_TEMP_PROT_DIS_O,
  input wire logic       WATCHDOG_INT_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);
  // defaults, role clamp, expiry side effects, bus-side timing
  chk_reset_vals: assert property ($rose(RESETN_I) |-> SDA_OEN_O && !CHARGE_ENABLE_O
    && FSW_CODE_O == FSW_500K && FREQ_SHIFT_O == 2'h0) else $error("reset value wrong");
  chk_role_clamp: assert property ((ROLE_I != 2'h0) [*5] |-> FSW_CODE_O <= FSW_500K)
    else $error("frequency not clamped");
  chk_int_single: assert property (WATCHDOG_INT_O |=> !WATCHDOG_INT_O [*8])
    else $error("expiry pulse too long");
  chk_int_chg_off: assert property (WATCHDOG_INT_O |-> !CHARGE_ENABLE_O)
    else $error("charge left on at expiry");
  chk_fsw_kept: assert property (WATCHDOG_INT_O |-> $stable(FSW_CODE_O))
    else $error("frequency moved at expiry");
  chk_cfg_kept: assert property (WATCHDOG_INT_O |-> $stable({FREQ_SHIFT_O,
    CONN_TEMP_PROT_DIS_O, BATT_TEMP_PROT_DIS_O, DIE_TEMP_PROT_DIS_O}))
    else $error("config moved at expiry");
  chk_sda_on_low: assert property ($changed(SDA_OEN_O) |-> !SCL_I)
    else $error("data line moved with clock high");
  chk_wr_on_low: assert property (($changed(FREQ_SHIFT_O) || $rose(CHARGE_ENABLE_O))
    |-> !SCL_I) else $error("write landed with clock high");
endmodule
bind ccw_regs ccw_regs_chk u_chk (.CLOCK_I, .RESETN_I, .SCL_I, .ROLE_I, .SDA_OEN_O,
  .CHARGE_ENABLE_O, .FSW_CODE_O, .FREQ_SHIFT_O, .CONN_TEMP_PROT_DIS_O,
  .BATT_TEMP_PROT_DIS_O, .DIE_TEMP_PROT_DIS_O, .WATCHDOG_INT_O);

// >>> ccw_host.sv
/* serial host model: start, stop, bytes, register transfers.
   assumes the bench resolves the pulled-up data line. */
`timescale 1ns/1ps
module ccw_host (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // step n edges, then just off the edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // 8 cycles per phase keeps the 6-cycle minimum and 4-cycle setup
  task automatic bitx(input logic b, output logic r);
    wt(4);
    sda_o = b;
    wt(4);
    scl_o = 1'b1;
    wt(8);
    r = sda_i;
    scl_o = 1'b0;
  endtask
  // a=0 gives (repeated) start, a=1 gives stop
  task automatic cond(input logic a);
    wt(4);
    sda_o = !a;
    wt(4);
    scl_o = 1'b1;
    wt(8);
    sda_o = a;
    wt(8);
    if (!a)
      scl_o = 1'b0;
  endtask
  task automatic xb(input logic [7:0] d, input logic m, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(m, k);
  endtask
  // pointer then one data byte, or restarted read ended by a nak
  task automatic xfer(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                      input logic rd, output logic [7:0] q, output logic nak);
    logic [7:0] t;
    logic       k0, k1, k2;
    cond(1'b0);
    xb({a, 1'b0}, 1'b1, t, k0);
    xb(p, 1'b1, t, k1);
    if (rd) begin
      cond(1'b0);
      xb({a, 1'b1}, 1'b1, t, k2);
      xb(8'hFF, 1'b1, q, t[0]);
    end else
      xb(d, 1'b1, t, k2);
    cond(1'b1); // every transfer completes within the period
    nak = k0 | k1 | k2;
  endtask
endmodule

// >>> tb_top.sv
/* bench for ccw_regs: host model on the pins, core inputs from here.
   assumes short watchdog periods set by parameter. */
`timescale 1ns/1ps
module tb_top
  import ccw_pkg::*;
;
  localparam logic [6:0] DEV = 7'h6A;
  localparam int         PER [4] = '{700, 900, 1100, 1400};
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [1:0] role = 2'h0;
  logic [6:0] alarm = 7'h00;
  logic       req = 1'b0, done = 1'b0, cont = 1'b0;
  logic       scl, sda_h, sd, oe_n, chg, dis_c, dis_b, dis_d, wint;
  logic [2:0] fsw;
  logic [1:0] shift;
  int         failures = 0, cmp_count = 0, int_cnt = 0, n;
  wire        sda = sda_h & (oe_n | sd); // pull-up when nobody drives low
  always #2.5 clk = ~clk;
  always @(negedge clk) if (wint === 1'b1) int_cnt++;
  ccw_regs #(.DEV_ADDR(DEV), .WD_CYC_0_P(WD_CNT_W'(PER[0])), .WD_CYC_1_P(WD_CNT_W'(PER[1])),
    .WD_CYC_2_P(WD_CNT_W'(PER[2])), .WD_CYC_3_P(WD_CNT_W'(PER[3]))) DUT (
    .CLOCK_I(clk), .RESETN_I(rst_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(sd), .SDA_OEN_O(oe_n),
    .ROLE_I(role), .ALARM_LIVE_I(alarm), .ADC_ONESHOT_REQ_I(req), .ADC_CONV_DONE_I(done),
    .ADC_CONTINUOUS_I(cont), .CHARGE_ENABLE_O(chg), .FSW_CODE_O(fsw), .FREQ_SHIFT_O(shift),
    .CONN_TEMP_PROT_DIS_O(dis_c), .BATT_TEMP_PROT_DIS_O(dis_b), .DIE_TEMP_PROT_DIS_O(dis_d),
    .WATCHDOG_INT_O(wint));
  ccw_host host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(sda_h));
  // ******************************
  // access and compare tasks
  // ******************************
  task automatic chk(input string s, input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] q;
    logic       nak;
    host.xfer(DEV, p, d, 1'b0, q, nak);
    chk("write ack", nak, 1'b0);
  endtask
  // ack and data checked together
  task automatic rd(input logic [7:0] p, input logic [7:0] e, input string s);
    logic [7:0] q;
    logic       nak;
    host.xfer(DEV, p, 8'h00, 1'b1, q, nak);
    chk(s, {nak, q}, {1'b0, e});
  endtask
  task automatic summarize;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard, well past the expected run
  initial begin
    #400_000;
    failures++;
    summarize();
  end
  // main sequence
  initial begin
    logic [7:0] q;
    logic       nak;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    rd(OFF_GEN_CTRL, GEN_CTRL_RST, "gen reset");
    rd(OFF_CHG_CTRL, CHG_CTRL_RST, "chg reset");
    wr(OFF_CHG_CTRL, 8'h9F);
    chk("chg pins", {chg, shift, dis_c, dis_b, dis_d}, 9'h03F);
    for (int c = 0; c < 16; c++) begin
      role = {c[3], c[0]};
      wr(OFF_GEN_CTRL, {1'b0, c[2:0], 4'h4});
      chk("fsw", fsw, (c[2:0] > 3'h4 && role != 2'h0) ? FSW_500K : c[2:0]);
      rd(OFF_CHG_CTRL, {1'b1, role, 5'h1F}, "role");
      rd(OFF_GEN_CTRL, {1'b0, c[2:0], 4'h4}, "gen rb");
    end
    host.wt(3000);
    chk("no expiry", int_cnt, 9'h000);
    role = 2'h0;
    wr(OFF_GEN_CTRL, 8'hD7);
    rd(OFF_GEN_CTRL, 8'h50, "soft reset");
    rd(OFF_CHG_CTRL, CHG_CTRL_RST, "soft chg");
    chk("fsw kept", {chg, dis_d, fsw}, 9'h005);
    alarm = 7'h55;
    rd(OFF_LIVE_STAT, 8'hAB, "stat");
    req = 1'b1;
    host.wt(1);
    req = 1'b0;
    alarm = 7'h2A;
    rd(OFF_LIVE_STAT, 8'h54, "stat req");
    done = 1'b1;
    host.wt(1);
    done = 1'b0;
    rd(OFF_LIVE_STAT, 8'h55, "stat done");
    cont = 1'b1;
    wr(OFF_LIVE_STAT, 8'hFF);
    rd(OFF_LIVE_STAT, 8'h54, "stat cont");
    rd(8'h20, UNMAPPED_RD_VAL, "unmapped");
    host.xfer(7'h11, OFF_CHG_CTRL, 8'h80, 1'b0, q, nak);
    chk("foreign nak", nak, 1'b1);
    for (int k = 0; k < 4; k++) begin
      wr(OFF_GEN_CTRL, {6'h10, k[1:0]});
      wr(OFF_CHG_CTRL, 8'h80);
      n = 0;
      while (wint !== 1'b1 && n < 3000) begin
        host.wt(1);
        n++;
      end
      chk("wd period", n >= PER[k] - 10 && n <= PER[k] + 10, 1'b1);
      chk("chg cleared", chg, 1'b0);
      rd(OFF_GEN_CTRL, {6'h12, k[1:0]}, "wd flag");
      rd(OFF_GEN_CTRL, {6'h10, k[1:0]}, "flag clear");
    end
    // foreign frame gave no restart, so one extra expiry during the first loop write
    chk("int count", 9'(int_cnt), 9'h005);
    summarize();
  end
endmodule
